// ---- rtl/mcec_top.sv ----
// capture channels, shared time base and quadrature encoder with apb registers
//
// The address map and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module mcec_top
    import mcec_pkg::*;
(
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RST_B,
    // apb slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [mcec_pkg::AW-1:0] PADDR,
    input  wire logic [31:0]           PWDATA,
    output var  logic [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // sensor pins
    input  wire logic                  CAPTURE_INPUT_ONE,
    input  wire logic                  CAPTURE_INPUT_TWO,
    input  wire logic                  CAPTURE_INPUT_THREE,
    input  wire logic                  PHASE_A_INPUT,
    input  wire logic                  PHASE_B_INPUT,
    input  wire logic                  INDEX_INPUT,
    // events
    output logic                       SPECIAL_TRIGGER,
    output logic                       VELOCITY_PULSE,
    output logic                       CHANNEL1_EVENT_FLAG,
    output logic                       CHANNEL2_POSITION_FLAG,
    output logic                       CHANNEL3_DIRECTION_FLAG
);
    import mcec_pkg::*;

    typedef struct packed {
        mcec_phase_e      ph;
        logic [5:0]       s1;      // first sync stage, pins
        logic [5:0]       s2;      // second sync stage
        logic [2:0]       smp;     // capture pins sampled at phase two
        logic [2:0]       p_rise;
        logic [2:0]       p_fall;
        logic [2:0]       eprev;   // phase a, phase b, index previous
        logic [2:0][3:0]  mode;
        logic [2:0]       ren;
        logic [2:0][3:0]  presc;
        logic [2:0]       armed;
        logic [2:0][15:0] cbuf;
        logic [15:0]      tb;
        logic             trd;
        logic [2:0]       flg;
        logic             vdis;
        logic             err;
        logic             dir;
        logic [2:0]       emode;
        logic [1:0]       velocity_pulse_divider;
        logic             idx_up;
        logic             idx_dn;
        logic [5:0]       post;
        logic             trig;
        logic             velp;
        logic [31:0]      rdata;
    } mcec_state_s;

    mcec_state_s q, d;

    logic        wr, rd_setup, enc_on, is_idx, is_x4;
    logic        ea, eb, ei, a_ev, b_ev, cnt_ev, up, tb_rst, cap_on;
    logic [5:0]  post_last;
    logic [2:0]  pins;
    logic [2:0]  set_f;
    logic        hit;

    assign pins     = {CAPTURE_INPUT_THREE, CAPTURE_INPUT_TWO, CAPTURE_INPUT_ONE};
    assign wr       = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign enc_on   = q.emode != E_OFF;
    assign is_idx   = q.emode == E_X2_IDX || q.emode == E_X4_IDX;
    assign is_x4    = q.emode == E_X4_IDX || q.emode == E_X4_PER;

    // decode of the synchronised encoder pins; gated by the encoder enable so they read low while the encoder is off
    assign ea   = q.s2[3] & enc_on;
    assign eb   = q.s2[4] & enc_on;
    assign ei   = q.s2[5] & enc_on;
    assign a_ev = enc_on & (ea != q.eprev[0]);
    assign b_ev = enc_on & (eb != q.eprev[1]);
    assign cnt_ev = a_ev | (is_x4 & b_ev);
    // phase a leading b means counting up
    assign up   = a_ev ? (ea ^ eb) : (b_ev ? ~(eb ^ ea) : q.dir);
    // ratio 1, 4, 16, 64 as last count value
    assign post_last = 6'((6'h01 << {q.velocity_pulse_divider, 1'b0}) - 6'h01);

    // apb handshake: zero wait state, unmapped addresses flag an error
    always_comb begin
        PREADY = 1'b1;
        hit = PADDR == A_CAPCTL0 || PADDR == A_CAPCTL1 || PADDR == A_CAPCTL2 || PADDR == A_TBCTL ||
              PADDR == A_TB || PADDR == A_BUF0 || PADDR == A_BUF1 || PADDR == A_BUF2 ||
              PADDR == A_ENC || PADDR == A_FLAGS;
        PSLVERR = PSEL & PENABLE & ~hit;
    end

    // next state of the whole block
    always_comb begin
        d      = q;
        set_f  = 3'b000;
        tb_rst = 1'b0;
        cap_on = 1'b0;
        d.trig = 1'b0;
        d.velp = 1'b0;
        d.s1   = {INDEX_INPUT, PHASE_B_INPUT, PHASE_A_INPUT, pins};
        d.s2   = q.s1;
        d.ph   = mcec_phase_e'(q.ph + 2'b01);

        // phase two samples the capture pins and remembers the edge
        if (q.ph == MCEC_Q2) begin
            d.smp    = q.s2[2:0] & {3{~enc_on}};
            d.p_rise = q.p_rise | (d.smp & ~q.smp);
            d.p_fall = q.p_fall | (~d.smp & q.smp);
        end

        // phase four acts on the remembered edges and ticks the time base
        if (q.ph == MCEC_Q4) begin
            d.p_rise = 3'b000;
            d.p_fall = 3'b000;
            d.tb     = 16'(q.tb + 16'h0001);
            for (int i = 0; i < 3; i++) begin
                cap_on = 1'b0;
                // encoder owns the pins, capture decode is skipped
                if (!enc_on) begin
                    case (q.mode[i])
                        M_FALL:   cap_on = q.p_fall[i];
                        M_RISE, M_PERIOD: cap_on = q.p_rise[i];
                        M_RISE4, M_RISE16: begin
                            if (q.p_rise[i]) begin
                                d.presc[i] = 4'(q.presc[i] + 4'h1);
                                if (q.armed[i] || q.presc[i] ==
                                    (q.mode[i] == M_RISE4 ? PRE4_LAST : PRE16_LAST)) begin
                                    cap_on     = 1'b1;
                                    d.presc[i] = 4'h0;
                                end
                            end
                        end
                        M_PW_FR, M_PW_RF: begin
                            // closing edge captures, any edge restarts the count
                            cap_on = q.armed[i] |
                                     (q.mode[i] == M_PW_FR ? q.p_rise[i] : q.p_fall[i]);
                            if (q.p_rise[i] | q.p_fall[i]) begin
                                tb_rst = 1'b1;
                            end
                            cap_on = cap_on & (q.p_rise[i] | q.p_fall[i]);
                        end
                        M_STATE:  cap_on = q.p_rise[i] | q.p_fall[i];
                        M_TRIG_F, M_TRIG_R: begin
                            if (i == 0 && (q.mode[i] == M_TRIG_F ? q.p_fall[i] : q.p_rise[i])) begin
                                d.trig = 1'b1;
                                if (!q.trd) begin
                                    tb_rst = 1'b1;
                                end
                            end
                        end
                        default:  cap_on = 1'b0;
                    endcase
                end
                if (cap_on) begin
                    d.cbuf[i]  = q.tb;
                    d.armed[i] = 1'b0;
                    set_f[i]   = 1'b1;
                    if (q.ren[i]) begin
                        tb_rst = 1'b1;
                    end
                end
            end
            // reset takes the place of the increment, only after the capture
            if (tb_rst) begin
                d.tb = ZERO16;
            end
        end

        // encoder: buffer 1 is the counter, buffer 2 the limit
        d.eprev = {ei, eb, ea};
        if (enc_on) begin
            if (ei & ~q.eprev[2]) begin
                d.idx_up = 1'b1;
            end
            if (~ei & q.eprev[2]) begin
                d.idx_dn = 1'b1;
            end
            if (a_ev | b_ev) begin
                d.dir = up;
                if (up != q.dir) begin
                    set_f[2] = 1'b1;
                end
            end
            if (cnt_ev) begin
                d.cbuf[1] = up ? 16'(q.cbuf[1] + 16'h0001) : 16'(q.cbuf[1] - 16'h0001);
                if (is_idx) begin
                    if ((up && q.cbuf[1] == ONES16) || (!up && q.cbuf[1] == ZERO16)) begin
                        d.err = 1'b1;
                    end
                    if (up && q.idx_up) begin
                        d.cbuf[1] = ZERO16;
                        set_f[1]  = 1'b1;
                    end else if (!up && q.idx_dn) begin
                        d.cbuf[1] = q.cbuf[2];
                        set_f[1]  = 1'b1;
                    end
                    d.idx_up = 1'b0;
                    d.idx_dn = 1'b0;
                end else begin
                    if ((up && q.cbuf[1] == q.cbuf[2]) || (up && q.cbuf[1] == ONES16)) begin
                        d.cbuf[1] = ZERO16;
                        set_f[1]  = 1'b1;
                    end else if (!up && q.cbuf[1] == ZERO16) begin
                        d.cbuf[1] = q.cbuf[2];
                        set_f[1]  = 1'b1;
                    end
                end
                // velocity pulses, one kept per postscaler ratio
                if (!q.vdis) begin
                    d.post = 6'(q.post + 6'h01);
                    if (q.post == post_last) begin
                        d.post    = 6'h00;
                        d.velp    = 1'b1;
                        d.cbuf[0] = q.tb;
                        set_f[0]  = 1'b1;
                    end
                end
            end
        end

        // register writes; a timer write beats a same-cycle capture
        if (wr) begin
            case (PADDR)
                A_CAPCTL0, A_CAPCTL1, A_CAPCTL2: begin
                    d.mode[PADDR[3:2]]  = PWDATA[3:0];
                    d.ren[PADDR[3:2]]   = PWDATA[REN_BIT];
                    d.armed[PADDR[3:2]] = 1'b1;
                    if (PWDATA[3:0] == M_OFF) begin
                        d.presc[PADDR[3:2]] = 4'h0;
                    end
                end
                A_TBCTL: d.trd = PWDATA[0];
                A_TB:    d.tb  = PWDATA[15:0];
                A_BUF0:  d.cbuf[0] = PWDATA[15:0];
                A_BUF1:  d.cbuf[1] = PWDATA[15:0];
                A_BUF2:  d.cbuf[2] = PWDATA[15:0];
                A_ENC: begin
                    d.vdis  = PWDATA[VDIS_BIT];
                    d.post  = 6'h00;                                  // a new ratio starts a fresh count
                    d.err   = PWDATA[ERR_BIT] | d.err & (PADDR != A_ENC);
                    d.emode = PWDATA[EMODE_LSB+2:EMODE_LSB];
                    d.velocity_pulse_divider  = PWDATA[1:0];
                end
                A_FLAGS: d.flg = q.flg & ~PWDATA[2:0];
                default: d.flg = d.flg;
            endcase
            // hardware error set beats the software clear
            if (PADDR == A_ENC && cnt_ev && is_idx &&
                ((up && q.cbuf[1] == ONES16) || (!up && q.cbuf[1] == ZERO16))) begin
                d.err = 1'b1;
            end
        end
        // flag set wins over the write-one clear
        d.flg = d.flg | set_f;

        // read data latched in the setup phase
        if (rd_setup) begin
            case (PADDR)
                A_CAPCTL0, A_CAPCTL1, A_CAPCTL2:
                    d.rdata = {24'h0, 1'b0, q.ren[PADDR[3:2]], 2'b00, q.mode[PADDR[3:2]]};
                A_TBCTL: d.rdata = {31'h0, q.trd};
                A_TB:    d.rdata = {16'h0, q.tb};
                A_BUF0:  d.rdata = {16'h0, q.cbuf[0]};
                A_BUF1:  d.rdata = {16'h0, q.cbuf[1]};
                A_BUF2:  d.rdata = {16'h0, q.cbuf[2]};
                A_ENC:   d.rdata = {24'h0, q.vdis, q.err, q.dir, q.emode, q.velocity_pulse_divider};
                A_FLAGS: d.rdata = {29'h0, q.flg};
                default: d.rdata = 32'h0;
            endcase
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            q       <= '0;
            q.ph    <= MCEC_Q1;
            q.mode  <= {3{MODE_RST}};
            q.emode <= EMODE_RST;
            q.vdis  <= VDIS_RST;
        end else begin
            q <= d;
        end
    end

    assign PRDATA                  = q.rdata;
    assign SPECIAL_TRIGGER         = q.trig;
    assign VELOCITY_PULSE          = q.velp;
    assign CHANNEL1_EVENT_FLAG     = q.flg[0];
    assign CHANNEL2_POSITION_FLAG  = q.flg[1];
    assign CHANNEL3_DIRECTION_FLAG = q.flg[2];

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // channel one trigger mode, kept as a net so its past value is plain
    logic trig_mode;
    assign trig_mode = q.mode[0] == M_TRIG_F || q.mode[0] == M_TRIG_R;
    trig_source_a: assert property (SPECIAL_TRIGGER |-> $past(trig_mode) && !$past(enc_on))
        else $error("trigger outside channel one trigger modes");
    enc_blocks_trig_a: assert property (enc_on |=> !SPECIAL_TRIGGER)
        else $error("trigger while encoder active");
    tb_write_wins_a: assert property (wr && PADDR == A_TB |=> q.tb == $past(PWDATA[15:0]))
        else $error("time base write lost");
    phase_act_a: assert property (q.ph == MCEC_Q4 |=> q.p_rise == 3'b000 && q.p_fall == 3'b000)
        else $error("edge not consumed at phase four");
    err_sticky_a: assert property (q.err && !(wr && PADDR == A_ENC) |=> q.err)
        else $error("error bit dropped without write");
    flag_set_wins_a: assert property (|set_f && wr && PADDR == A_FLAGS |=> (q.flg & $past(set_f)) == $past(set_f))
        else $error("flag set lost to clear");
    dir_flag_a: assert property (enc_on && (a_ev || b_ev) && up != q.dir |=> q.flg[2])
        else $error("direction change not flagged");
    // any edge of channel two in M_PW_FR pulse-width mode, no timer write in the way
    sequence pw_edge_s;
        q.ph == MCEC_Q4 && !enc_on && q.mode[1] == M_PW_FR && (q.p_rise[1] || q.p_fall[1]) &&
        !(wr && PADDR == A_TB);
    endsequence
    pw_reset_a: assert property (pw_edge_s |=> q.tb == ZERO16)
        else $error("pulse width edge did not reset time base");
    post_one_a: assert property (enc_on && cnt_ev && !q.vdis && q.velocity_pulse_divider == 2'b00 |=> VELOCITY_PULSE)
        else $error("postscaler 1:1 missed a pulse");
endmodule
`default_nettype wire

// ---- inc/mcec_pkg.sv ----
// constants and types shared by the motion capture and encoder block
`default_nettype none
package mcec_pkg;
    localparam int          DW          = 16;
    localparam int          AW          = 8;
    // register byte addresses on the apb bus
    localparam logic [7:0]  A_CAPCTL0   = 8'h00;
    localparam logic [7:0]  A_CAPCTL1   = 8'h04;
    localparam logic [7:0]  A_CAPCTL2   = 8'h08;
    localparam logic [7:0]  A_TBCTL     = 8'h0c;
    localparam logic [7:0]  A_TB        = 8'h10;
    localparam logic [7:0]  A_BUF0      = 8'h14;
    localparam logic [7:0]  A_BUF1      = 8'h18;
    localparam logic [7:0]  A_BUF2      = 8'h1c;
    localparam logic [7:0]  A_ENC       = 8'h20;
    localparam logic [7:0]  A_FLAGS     = 8'h24;
    // field positions
    localparam int          REN_BIT     = 6;
    localparam int          VDIS_BIT    = 7;
    localparam int          ERR_BIT     = 6;
    localparam int          DIR_BIT     = 5;
    localparam int          EMODE_LSB   = 2;
    // reset values
    localparam logic [3:0]  MODE_RST    = 4'h0;
    localparam logic [2:0]  EMODE_RST   = 3'h0;
    localparam logic        VDIS_RST    = 1'b0;
    localparam logic [15:0] ZERO16      = 16'h0000;
    localparam logic [15:0] ONES16      = 16'hffff;
    // capture mode codes
    localparam logic [3:0]  M_OFF       = 4'h0;
    localparam logic [3:0]  M_FALL      = 4'h1;
    localparam logic [3:0]  M_RISE      = 4'h2;
    localparam logic [3:0]  M_RISE4     = 4'h3;
    localparam logic [3:0]  M_RISE16    = 4'h4;
    localparam logic [3:0]  M_PERIOD    = 4'h5;
    localparam logic [3:0]  M_PW_FR     = 4'h6;
    localparam logic [3:0]  M_PW_RF     = 4'h7;
    localparam logic [3:0]  M_STATE     = 4'h8;
    localparam logic [3:0]  M_TRIG_F    = 4'he;
    localparam logic [3:0]  M_TRIG_R    = 4'hf;
    localparam logic [3:0]  PRE4_LAST   = 4'h3;
    localparam logic [3:0]  PRE16_LAST  = 4'hf;
    // encoder mode codes
    localparam logic [2:0]  E_OFF       = 3'h0;
    localparam logic [2:0]  E_X2_IDX    = 3'h1;
    localparam logic [2:0]  E_X2_PER    = 3'h2;
    localparam logic [2:0]  E_X4_IDX    = 3'h5;
    localparam logic [2:0]  E_X4_PER    = 3'h6;
    // instruction cycle phases, one clock each, four per cycle
    typedef enum logic [1:0] {
        MCEC_Q1 = 2'b00,
        MCEC_Q2 = 2'b01,
        MCEC_Q3 = 2'b10,
        MCEC_Q4 = 2'b11
    } mcec_phase_e;
endpackage
`default_nettype wire

// ---- bench/mcec_sensor_model.sv ----
// sensor side model: hall style capture pins and a quadrature encoder
`default_nettype none
module mcec_sensor_model (
    // clock
    input  wire logic       clk,
    // pins towards the block
    output var  logic [2:0] cap_pins,
    output var  logic       phase_a,
    output var  logic       phase_b,
    output var  logic       index_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] quad_q;

    // idle pins low, encoder parked at state 0
    initial begin
        cap_pins = 3'h0;
        phase_a = 1'b0;
        phase_b = 1'b0;
        index_pin = 1'b0;
        quad_q = 2'h0;
    end

    // every level is held 16 clocks, far above the 4-clock minimum pulse
    task automatic set_cap(input int ch, input logic lvl);
        @(posedge clk);
        cap_pins[ch] <= lvl;
        repeat (16) @(posedge clk);
    endtask

    // one quadrature step; forward means phase A leads phase B
    task automatic step(input logic fwd);
        logic [1:0] q;
        q = fwd ? quad_q + 2'h1 : quad_q - 2'h1;
        @(posedge clk);
        quad_q <= q;
        phase_a <= q[1] ^ q[0];
        phase_b <= q[1];
        repeat (16) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- bench/test_motion_capture_encoder_control.sv ----
// self-checking bench for the capture and encoder block over apb
`default_nettype none
module test_motion_capture_encoder_control;
    timeunit 1ns;
    timeprecision 1ps;
    import mcec_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  cap_pins;
    logic        ph_a;
    logic        ph_b;
    logic        idx;
    logic        trig;
    logic        vel;
    logic [2:0]  flags;
    logic [31:0] r;
    logic        e;
    int          n_fail;
    int          n_tests;
    int          n_trig;
    int          n_vel;
    logic [31:0] keep;
    logic [2:0]  emodes [2] = '{E_X4_IDX, E_X2_IDX};
    logic [31:0] ecount [2] = '{32'h4, 32'h2};

    mcec_top i_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CAPTURE_INPUT_ONE(cap_pins[0]), .CAPTURE_INPUT_TWO(cap_pins[1]),
        .CAPTURE_INPUT_THREE(cap_pins[2]), .PHASE_A_INPUT(ph_a), .PHASE_B_INPUT(ph_b),
        .INDEX_INPUT(idx), .SPECIAL_TRIGGER(trig), .VELOCITY_PULSE(vel),
        .CHANNEL1_EVENT_FLAG(flags[0]), .CHANNEL2_POSITION_FLAG(flags[1]),
        .CHANNEL3_DIRECTION_FLAG(flags[2]));

    mcec_sensor_model i_sens (.clk(clk), .cap_pins(cap_pins), .phase_a(ph_a), .phase_b(ph_b),
        .index_pin(idx));

    // free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // count trigger and velocity pulses; each stands one cycle
    always @(posedge clk) begin
        if (trig === 1'b1) n_trig++;
        if (vel === 1'b1) n_vel++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        forever begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // cut a hang short well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // reset values of every register but the running time base
        for (int i = 0; i < 10; i++) begin
            if (i != 4) rd(8'(i * 4));
            if (i != 4) check(r, 32'h0);
        end
        rd(8'h40);
        check({r[30:0], e}, 32'h1);
        // both index encoder mode codes read back in their field
        foreach (emodes[i]) begin
            wr(A_ENC, {24'h0, 1'b1, 2'h0, emodes[i], 2'h0});
            rd(A_ENC);
            check(32'(r[4:2]), 32'(emodes[i]));
        end
        wr(A_ENC, 32'h0);
        // rising edge capture with time base reset
        wr(A_TB, 32'h1000);
        wr(A_CAPCTL0, 32'h42);
        i_sens.set_cap(0, 1'b1);
        rd(A_BUF0);
        check(32'(r >= 32'h1000 && r <= 32'h1008), 32'h1);
        rd(A_TB);
        check(32'(r < 32'h10), 32'h1);
        check(32'(flags[0]), 32'h1);
        // a falling edge leaves the buffer alone in rising mode
        rd(A_BUF0);
        keep = r;
        i_sens.set_cap(0, 1'b0);
        rd(A_BUF0);
        check(r, keep);
        // a mode change keeps the count
        wr(A_TB, 32'h0300);
        wr(A_CAPCTL1, 32'(M_PERIOD));
        rd(A_TB);
        check(32'(r >= 32'h300 && r <= 32'h302), 32'h1);
        // pulse width resets even with reset enable clear
        wr(A_CAPCTL1, 32'(M_PW_FR));
        wr(A_TB, 32'h2000);
        i_sens.set_cap(1, 1'b1);
        rd(A_TB);
        check(32'(r < 32'h10), 32'h1);
        check(32'(flags[1]), 32'h1);
        // falling trigger resets the time base, no channel flag
        wr(A_FLAGS, 32'h7);
        wr(A_TBCTL, 32'h0);
        wr(A_CAPCTL0, 32'(M_TRIG_F));
        i_sens.set_cap(0, 1'b1);
        n_trig = 0;
        wr(A_TB, 32'h3000);
        i_sens.set_cap(0, 1'b0);
        rd(A_TB);
        check(32'(r < 32'h10), 32'h1);
        check(32'(n_trig), 32'h1);
        check(32'(flags[0]), 32'h0);
        // rising trigger with its reset disabled
        wr(A_TBCTL, 32'h1);
        wr(A_CAPCTL0, 32'(M_TRIG_R));
        wr(A_TB, 32'h3000);
        i_sens.set_cap(0, 1'b1);
        rd(A_TB);
        check(32'(r >= 32'h3000), 32'h1);
        check(32'(n_trig), 32'h2);
        // encoder enabled over a live capture channel
        wr(A_CAPCTL0, 32'(M_RISE));
        foreach (emodes[i]) begin
            // velocity on in the first pass only, 1:1 postscaler
            wr(A_ENC, {24'h0, 1'(i), 2'h0, emodes[i], 2'h0});
            wr(A_BUF1, 32'h0);
            n_vel = 0;
            repeat (4) i_sens.step(1'b1);
            check(32'(n_vel), i == 0 ? ecount[i] : 32'h0);
            rd(A_BUF1);
            check(r, ecount[i]);
            check(32'(r[5]), 32'h0);
            rd(A_ENC);
            check(32'(r[5]), 32'h1);
        end
        // velocity pulses captured the running time base into buffer 0
        rd(A_BUF0);
        check(32'(r >= 32'h3000 && r <= 32'hffff), 32'h1);
        wr(A_FLAGS, 32'h7);
        i_sens.set_cap(0, 1'b0);
        i_sens.set_cap(0, 1'b1);
        check(32'(flags[0]), 32'h0);
        // reversal: one phase A edge in two steps counts down once
        i_sens.step(1'b0);
        i_sens.step(1'b0);
        rd(A_BUF1);
        check(r, 32'h1);
        rd(A_ENC);
        check(32'(r[5]), 32'h0);
        check(32'(flags[2]), 32'h1);
        // counting below zero in index mode raises the error until software clears it
        wr(A_BUF1, 32'h0);
        i_sens.step(1'b0);
        i_sens.step(1'b0);
        rd(A_BUF1);
        check(r, 32'hffff);
        rd(A_ENC);
        check(32'(r[6]), 32'h1);
        wr(A_ENC, {24'h0, 1'b1, 2'h0, E_X2_IDX, 2'h0});
        rd(A_ENC);
        check(32'(r[6]), 32'h0);
        wr(A_ENC, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
